//--- rtl/bms_top.sv
// Basic multiplier set: lanes, result FIFO and top level datapath
//
// Notes on behaviour
// - Basic multiply depends only on function code and operand size.
// - Lanes are 1x32 to 64, 2x16 to 32, or 4x8 to 16 bits.
// - Lane size comes from the second factor's size attribute.
// - Each factor signed or unsigned; any signed factor gives signed product.
// - Code bits 1:0 pick sign: uu, us, su, ss.
// - Codes 0-3 integer, 4-7 normalised, 8-B fixed, C-F graphics.
// - All 48 size, sign and type combinations work independently.
// - Type and sign of each multiply are kept in the setup register.
// - Normalised shifts product right by p, fixed point by p/2.
// - 32-bit lane: integer 31:0, fixed 47:16, normalised upper half.
// - 16-bit lane: integer 15:0, fixed 23:8, normalised 31:16.
// - 8-bit lane: integer 7:0, fixed 11:4, normalised 15:8.
// - Unsigned graphics scales by 2^n/(2^n-1): all ones means one.
// - Signed graphics scales by 2^(n-1)/(2^(n-1)-1).
// - Result appears five cycles after the request, for every type.
// - One new multiply per cycle; type may change every cycle.
// - Selected product lands in the result bus register.
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/10ps

// ******************************************************************
// Result FIFO
// ******************************************************************
module bms_fifo #(
  parameter int W = 32,
  parameter int D = 32,
  parameter int C = 6
) (
  input  wire logic         i_clk,   // Clock
  input  wire logic         i_rst_n, // Synchronous reset, active low
  input  wire logic         i_valid, // Fill side valid
  output logic              o_ready, // Fill side ready
  input  wire logic [W-1:0] i_data,  // Fill side data
  output logic              o_valid, // Drain side valid
  input  wire logic         i_ready, // Drain side ready
  output logic [W-1:0]      o_data,  // Drain side data
  output logic [C-1:0]      o_count  // Words held
);
  localparam int AW = $clog2(D);
  localparam logic [C-1:0] FULL_CNT = C'(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [C-1:0]  count_reg;
  logic          push;
  logic          pop;

  assign o_ready = (count_reg != FULL_CNT);
  assign o_valid = (count_reg != '0);
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_data  = mem[rd_ptr_reg];
  assign o_count = count_reg;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + C'(1);
    end else if (pop && !push) begin
      count_reg <= count_reg - C'(1);
    end
  end

endmodule : bms_fifo

// ******************************************************************
// One multiplier lane of width N, three registered stages
// ******************************************************************
module bms_lane
  import bms_pkg::*;
#(
  parameter int N = 8
) (
  input  wire logic         i_clk,   // Clock
  input  wire logic [N-1:0] i_a,     // First factor lane
  input  wire logic [N-1:0] i_b,     // Second factor lane
  input  wire logic         i_a_sgn, // First factor is signed
  input  wire logic         i_b_sgn, // Second factor is signed
  input  wire logic [1:0]   i_dtype, // Data type of the product
  output logic [N-1:0]      o_lane   // Selected lane result
);

  localparam logic signed [2*N+1:0] ONE = (2*N+2)'(1);

  logic signed [N:0]     a_ext;
  logic signed [N:0]     b_ext;
  logic signed [2*N+1:0] prod_reg;
  logic signed [2*N+1:0] prod2_reg;
  logic signed [2*N+1:0] scaled_reg;
  logic signed [2*N+1:0] scaled_next;
  logic [1:0]            dt1_reg;
  logic [1:0]            dt2_reg;
  logic                  sgn1_reg;

  // Sign bit extends only a signed factor
  assign a_ext = $signed({i_a_sgn & i_a[N-1], i_a});
  assign b_ext = $signed({i_b_sgn & i_b[N-1], i_b});

  always_ff @(posedge i_clk) begin
    prod_reg <= a_ext * b_ext;
    dt1_reg  <= i_dtype;
    sgn1_reg <= i_a_sgn | i_b_sgn;
  end

  // x*2^k/(2^k-1) is taken as x + x/2^k + 1 before the upper half is
  // kept; the +1 makes all-ones times v come out as v exactly
  always_comb begin
    if (sgn1_reg) begin
      scaled_next = prod_reg + (prod_reg >>> (N - 1)) + ONE;
    end else begin
      scaled_next = prod_reg + (prod_reg >>> N) + ONE;
    end
  end

  always_ff @(posedge i_clk) begin
    prod2_reg  <= prod_reg;
    scaled_reg <= scaled_next;
    dt2_reg    <= dt1_reg;
  end

  // Plain bit selection: lower bits are dropped, no rounding
  always_ff @(posedge i_clk) begin
    case (dt2_reg)
      TYPE_INT:  o_lane <= prod2_reg[N-1:0];
      TYPE_FIX:  o_lane <= prod2_reg[N+N/2-1:N/2];
      TYPE_NORM: o_lane <= prod2_reg[2*N-1:N];
      TYPE_GFX:  o_lane <= scaled_reg[2*N-1:N];
      default:   o_lane <= prod2_reg[N-1:0];
    endcase
  end

endmodule : bms_lane

// ******************************************************************
// Top level
// ******************************************************************
module bms_top
  import bms_pkg::*;
(
  input  wire logic              i_clk,          // Clock, 10 MHz
  input  wire logic              i_rst_n,        // Sync reset, active low
  input  wire logic              i_valid,        // Multiply request
  output logic                   o_ready,        // Request can be taken
  input  wire bms_req_type       i_req,          // Code, size, factors
  output logic [WORD_W-1:0]      o_result,       // Result bus register
  output logic                   o_result_valid, // Result bus updated
  output logic [WORD_W-1:0]      o_fifo_data,    // Buffered result
  output logic                   o_fifo_valid,   // Buffered result valid
  input  wire logic              i_fifo_ready,   // Drain accepts result
  input  wire logic [3:0]        i_addr,         // Register address
  input  wire logic [WORD_W-1:0] i_wdata,        // Register write data
  input  wire logic              i_wr,           // Register write strobe
  input  wire logic              i_rd,           // Register read strobe
  output logic [WORD_W-1:0]      o_rdata         // Read data, next cycle
);

  // ****************************************************************
  // Request decode
  // ****************************************************************
  logic        take;
  bms_ctl_type ctl_next;
  bms_req_type req_reg;
  bms_ctl_type ctl_reg;
  bms_ctl_type ctl_pipe [3];
  logic [3:0]  vld_reg;
  logic        cap_reg;
  logic [3:0]  setup_reg;
  logic [CNT_W-1:0] fifo_count;
  logic        fifo_in_ready;
  logic [CNT_W-1:0] inflight;

  assign take = i_valid && o_ready;

  // The control registers play no part here: type and sign come from
  // the code, the lane size from the second factor
  always_comb begin
    ctl_next.dtype = i_req.func[FUNC_TYPE_LSB +: 2];
    ctl_next.a_sgn = i_req.func[FUNC_SIGN_A_BIT];
    ctl_next.b_sgn = i_req.func[FUNC_SIGN_B_BIT];
    ctl_next.size  = i_req.b_size;
  end

  // Every stage takes a fresh request each cycle, so fields never
  // interlock and any of the 48 combinations may follow any other
  always_ff @(posedge i_clk) begin
    req_reg <= i_req;
    ctl_reg <= ctl_next;
    ctl_pipe[0] <= ctl_reg;
    ctl_pipe[1] <= ctl_pipe[0];
    ctl_pipe[2] <= ctl_pipe[1];
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      vld_reg <= '0;
    end else begin
      vld_reg <= {vld_reg[2:0], take};
    end
  end

  // ****************************************************************
  // Lanes
  // ****************************************************************
  logic [7:0]  lane8  [4];
  logic [15:0] lane16 [2];
  logic [31:0] lane32;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_q8
      bms_lane #(.N(8)) u_lane (
        .i_clk   (i_clk),
        .i_a     (req_reg.a[8*g +: 8]),
        .i_b     (req_reg.b[8*g +: 8]),
        .i_a_sgn (ctl_reg.a_sgn),
        .i_b_sgn (ctl_reg.b_sgn),
        .i_dtype (ctl_reg.dtype),
        .o_lane  (lane8[g])
      );
    end
    for (g = 0; g < 2; g++) begin : g_d16
      bms_lane #(.N(16)) u_lane (
        .i_clk   (i_clk),
        .i_a     (req_reg.a[16*g +: 16]),
        .i_b     (req_reg.b[16*g +: 16]),
        .i_a_sgn (ctl_reg.a_sgn),
        .i_b_sgn (ctl_reg.b_sgn),
        .i_dtype (ctl_reg.dtype),
        .o_lane  (lane16[g])
      );
    end
  endgenerate

  bms_lane #(.N(32)) u_s32 (
    .i_clk   (i_clk),
    .i_a     (req_reg.a),
    .i_b     (req_reg.b),
    .i_a_sgn (ctl_reg.a_sgn),
    .i_b_sgn (ctl_reg.b_sgn),
    .i_dtype (ctl_reg.dtype),
    .o_lane  (lane32)
  );

  // ****************************************************************
  // Result bus register
  // ****************************************************************
  logic [WORD_W-1:0] result_next;

  always_comb begin
    case (ctl_pipe[2].size)
      SIZE_2X16: result_next = {lane16[1], lane16[0]};
      SIZE_4X8:  result_next = {lane8[3], lane8[2], lane8[1], lane8[0]};
      default:   result_next = lane32;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_result       <= '0;
      o_result_valid <= 1'b0;
    end else begin
      o_result_valid <= vld_reg[3];
      if (vld_reg[3]) begin
        o_result <= result_next;
      end
    end
  end

  // ****************************************************************
  // Result FIFO and back-pressure
  // ****************************************************************
  // Requests are refused only when the words already in flight could
  // overflow the FIFO; the pipeline itself never stalls
  always_comb begin
    inflight = '0;
    for (int k = 0; k < 4; k++) begin
      inflight = inflight + CNT_W'(vld_reg[k]);
    end
    inflight = inflight + CNT_W'(o_result_valid);
  end

  assign o_ready = !cap_reg ||
                   ((fifo_count + inflight) < CNT_W'(FIFO_DEPTH));

  bms_fifo #(.W(WORD_W), .D(FIFO_DEPTH), .C(CNT_W)) u_fifo (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_valid (o_result_valid && cap_reg),
    .o_ready (fifo_in_ready),
    .i_data  (o_result),
    .o_valid (o_fifo_valid),
    .i_ready (i_fifo_ready),
    .o_data  (o_fifo_data),
    .o_count (fifo_count)
  );

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic wr_setup;
  logic wr_ctrl;

  assign wr_setup = i_wr && (i_addr == REG_SETUP);
  assign wr_ctrl  = i_wr && (i_addr == REG_CTRL);

  // A multiply taken in the same cycle as a software write wins
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      setup_reg <= SETUP_RESET;
    end else if (take) begin
      setup_reg <= {ctl_next.dtype, ctl_next.a_sgn, ctl_next.b_sgn};
    end else if (wr_setup) begin
      setup_reg <= i_wdata[3:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cap_reg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      cap_reg <= i_wdata[CTRL_CAPTURE_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      case (i_addr)
        REG_SETUP:  o_rdata <= {28'h0, setup_reg};
        REG_CTRL:   o_rdata <= {31'h0, cap_reg};
        REG_STATUS: begin
          o_rdata <= '0;
          o_rdata[STAT_BUSY_BIT]  <= (inflight != '0);
          o_rdata[STAT_EMPTY_BIT] <= !o_fifo_valid;
          o_rdata[STAT_FULL_BIT]  <= !fifo_in_ready;
          o_rdata[STAT_COUNT_LSB +: CNT_W] <= fifo_count;
        end
        REG_RESULT: o_rdata <= o_result;
        default:    o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_take(logic [3:0] f, logic [1:0] sz);
    take && i_req.func == f && i_req.b_size == sz;
  endsequence

  result_latency_a: assert property (
    take && !$past(take) |-> ##4 !o_result_valid ##1 o_result_valid)
    else $error("result not valid five cycles after request");

  back_to_back_a: assert property (
    take ##1 take |-> ##4 o_result_valid ##1 o_result_valid)
    else $error("back to back requests lost a result");

  setup_record_a: assert property (
    take |=> setup_reg == {$past(i_req.func)})
    else $error("setup register does not hold type and sign");

  property p_int32;
    logic [63:0] p;
    (s_take(4'h0, SIZE_1X32), p = 64'(i_req.a) * 64'(i_req.b))
      |-> ##5 o_result == p[31:0];
  endproperty
  int32_out_a: assert property (p_int32)
    else $error("integer 32 bit result wrong");

  property p_fix32;
    logic [63:0] p;
    (s_take(4'h8, SIZE_1X32), p = 64'(i_req.a) * 64'(i_req.b))
      |-> ##5 o_result == p[47:16];
  endproperty
  fix32_out_a: assert property (p_fix32)
    else $error("fixed point 32 bit result wrong");

  property p_fss32;
    logic signed [63:0] p;
    (s_take(4'hb, SIZE_1X32),
     p = 64'($signed(i_req.a)) * 64'($signed(i_req.b)))
      |-> ##5 o_result == p[47:16];
  endproperty
  signed_fix_a: assert property (p_fss32)
    else $error("signed fixed point 32 bit result wrong");

  property p_norm16;
    logic [31:0] p0;
    logic [31:0] p1;
    (s_take(4'h4, SIZE_2X16),
     p0 = 32'(i_req.a[15:0]) * 32'(i_req.b[15:0]),
     p1 = 32'(i_req.a[31:16]) * 32'(i_req.b[31:16]))
      |-> ##5 o_result == {p1[31:16], p0[31:16]};
  endproperty
  norm16_out_a: assert property (p_norm16)
    else $error("normalised 2x16 result wrong");

  property p_int8;
    logic [15:0] p;
    (s_take(4'h0, SIZE_4X8), p = 16'(i_req.a[7:0]) * 16'(i_req.b[7:0]))
      |-> ##5 o_result[7:0] == p[7:0];
  endproperty
  int8_out_a: assert property (p_int8)
    else $error("integer 4x8 lane result wrong");

  property p_gfx8;
    logic [7:0] a;
    (s_take(4'hc, SIZE_4X8) ##0 i_req.b[7:0] == 8'hff, a = i_req.a[7:0])
      |-> ##5 o_result[7:0] == a;
  endproperty
  gfx_unity_a: assert property (p_gfx8)
    else $error("graphics all ones factor is not one");

  fifo_safe_a: assert property (
    o_result_valid && cap_reg |-> fifo_in_ready)
    else $error("result arrived with the fifo full");

endmodule : bms_top

//--- rtl/bms_pkg.sv
// Shared constants and carrier types of the basic multiplier set
package bms_pkg;

  // ****************************************************************
  // Widths and depths
  // ****************************************************************
  localparam int WORD_W      = 32;
  localparam int PROD_W      = 64;
  localparam int FIFO_DEPTH  = 32;
  localparam int PIPE_STAGES = 5;
  localparam int CNT_W       = 6;

  // ****************************************************************
  // Lane size attribute of the second factor
  // ****************************************************************
  localparam logic [1:0] SIZE_1X32 = 2'h0;
  localparam logic [1:0] SIZE_2X16 = 2'h1;
  localparam logic [1:0] SIZE_4X8  = 2'h2;

  // ****************************************************************
  // Function code fields and data types
  // ****************************************************************
  localparam int FUNC_SIGN_B_BIT = 0;
  localparam int FUNC_SIGN_A_BIT = 1;
  localparam int FUNC_TYPE_LSB   = 2;
  localparam logic [1:0] TYPE_INT  = 2'h0;
  localparam logic [1:0] TYPE_NORM = 2'h1;
  localparam logic [1:0] TYPE_FIX  = 2'h2;
  localparam logic [1:0] TYPE_GFX  = 2'h3;

  // ****************************************************************
  // Register map, fields and reset values
  // ****************************************************************
  localparam logic [3:0] REG_SETUP  = 4'h0;
  localparam logic [3:0] REG_CTRL   = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_RESULT = 4'hc;
  localparam int CTRL_CAPTURE_BIT   = 0;
  localparam int STAT_BUSY_BIT      = 0;
  localparam int STAT_EMPTY_BIT     = 1;
  localparam int STAT_FULL_BIT      = 2;
  localparam int STAT_COUNT_LSB     = 8;
  localparam logic [3:0] SETUP_RESET = 4'h0;
  localparam logic       CTRL_RESET  = 1'b1;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [3:0]        func;
    logic [1:0]        b_size;
    logic [WORD_W-1:0] a;
    logic [WORD_W-1:0] b;
  } bms_req_type;

  typedef struct packed {
    logic [1:0] dtype;
    logic       a_sgn;
    logic       b_sgn;
    logic [1:0] size;
  } bms_ctl_type;

endpackage : bms_pkg

//--- test/bms_bus_model.sv
// Far side of the result FIFO: the bus that drains buffered products
`timescale 1ns/10ps

module bms_bus_model (
  input  wire logic i_clk,   // Clock
  input  wire logic i_rst_n, // Sync reset, active low
  input  wire logic i_hold,  // Stall the drain completely
  input  wire logic i_slow,  // Take a word only every other cycle
  output logic      o_ready  // Drain accepts the head word
);

  // ****************************************************************
  // Drain pacing
  // ****************************************************************
  // Ready is registered, so a stall always lasts at least one cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_hold) begin
      o_ready <= 1'b0;
    end else if (i_slow) begin
      o_ready <= ~o_ready;
    end else begin
      o_ready <= 1'b1;
    end
  end

endmodule : bms_bus_model

//--- test/bms_top_test.sv
// Self-checking bench of the basic multiplier set with a reference model
`timescale 1ns/10ps

module bms_top_test;
  import bms_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic              i_clk;
  logic              i_rst_n;
  logic              i_valid;
  logic              o_ready;
  bms_req_type       i_req;
  logic [WORD_W-1:0] o_result;
  logic              o_result_valid;
  logic [WORD_W-1:0] o_fifo_data;
  logic              o_fifo_valid;
  logic              fifo_rdy;
  logic [3:0]        i_addr;
  logic [WORD_W-1:0] i_wdata;
  logic              i_wr;
  logic              i_rd;
  logic [WORD_W-1:0] o_rdata;
  logic              hold;
  logic              slow;
  logic [31:0]       lf = 32'h59;
  logic [31:0]       eq[$];
  logic [31:0]       fq[$];
  int                tq[$];
  int                cyc, ntaken, n0, bad_count, checks;
  logic              cap = 1'b1;
  logic [3:0]        last_f;
  logic [31:0]       last_r;

  bms_top u_bms_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(i_valid),
    .o_ready(o_ready), .i_req(i_req), .o_result(o_result),
    .o_result_valid(o_result_valid), .o_fifo_data(o_fifo_data),
    .o_fifo_valid(o_fifo_valid), .i_fifo_ready(fifo_rdy), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));

  bms_bus_model u_bms_bus_model (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_hold(hold), .i_slow(slow), .o_ready(fifo_rdy));

  always #50 i_clk = ~i_clk;

  // ****************************************************************
  // Reference model and helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction : rnd

  function automatic logic [31:0] model(logic [3:0] f, logic [1:0] z,
                                        logic [31:0] a, logic [31:0] b);
    int          n;
    int          k;
    logic [63:0] m, av, bv, p, s;
    logic [31:0] r;
    n = (z == SIZE_2X16) ? 16 : (z == SIZE_4X8) ? 8 : 32;
    m = (64'h1 << n) - 64'h1;
    r = '0;
    for (int l = 0; l < 32 / n; l++) begin
      av = (64'(a) >> (l * n)) & m;
      bv = (64'(b) >> (l * n)) & m;
      if (f[1] && av[n-1]) av = av | ~m;
      if (f[0] && bv[n-1]) bv = bv | ~m;
      p = av * bv;
      k = (f[1] | f[0]) ? n - 1 : n;
      case (f[3:2])
        TYPE_INT:  s = p;
        TYPE_NORM: s = p >> n;
        TYPE_FIX:  s = p >> (n / 2);
        default:   s = (p + ((f[1] | f[0]) ? 64'($signed(p) >>> k) : p >> k)
                        + 64'h1) >> n;
      endcase
      r = r | 32'((s & m) << (l * n));
    end
    return r;
  endfunction : model

  task automatic check(logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic drv(logic [3:0] f, logic [1:0] z, logic [31:0] a,
                     logic [31:0] b);
    // Request stands until the edge at which it is taken
    i_valid <= 1'b1;
    i_req   <= '{f, z, a, b};
    @(posedge i_clk);
    while (!o_ready) @(posedge i_clk);
  endtask : drv

  task automatic idle(int n);
    i_valid <= 1'b0;
    repeat (n) @(posedge i_clk);
  endtask : idle

  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd_chk(logic [3:0] a, logic [31:0] e);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    @(posedge i_clk);
    check(o_rdata, e);
  endtask : rd_chk

  task automatic print_verdict();
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  // ****************************************************************
  // Monitor: values sampled at the edge are those of the cycle before
  // ****************************************************************
  always @(posedge i_clk) begin
    cyc++;
    if (i_rst_n && i_valid && o_ready) begin
      eq.push_back(model(i_req.func, i_req.b_size, i_req.a, i_req.b));
      tq.push_back(cyc);
      ntaken++;
      last_f = i_req.func;
    end
    if (o_result_valid) begin
      if (eq.size() == 0) check(32'h1, 32'h0);
      else begin
        check(32'(cyc - tq.pop_front()), 32'h5);
        last_r = eq.pop_front();
        check(o_result, last_r);
        if (cap) fq.push_back(last_r);
      end
    end
    if (o_fifo_valid && fifo_rdy) begin
      if (fq.size() == 0) check(32'h1, 32'h0);
      else check(o_fifo_data, fq.pop_front());
    end
    if (i_rst_n && !cap) check(32'(o_ready), 32'h1);
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    i_clk = 1'b0; i_rst_n = 1'b0; i_valid = 1'b0; i_req = '0;
    i_addr = '0; i_wdata = '0; i_wr = 1'b0; i_rd = 1'b0;
    hold = 1'b0; slow = 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd_chk(REG_SETUP, 32'(SETUP_RESET));
    rd_chk(REG_CTRL, 32'(CTRL_RESET));
    rd_chk(REG_STATUS, 32'h2);
    for (int f = 0; f < 16; f++) begin
      for (int z = 0; z < 3; z++) begin
        drv(4'(f), 2'(z), rnd(), rnd());
      end
    end
    drv(4'hc, SIZE_4X8, rnd(), 32'hffffffff);
    drv(4'hf, SIZE_2X16, 32'h7fff7fff, rnd());
    drv(4'hd, SIZE_1X32, rnd(), rnd());
    idle(8);
    rd_chk(REG_SETUP, 32'(last_f));
    rd_chk(REG_RESULT, last_r);
    rd_chk(4'h2, 32'h0);
    wr(REG_RESULT, 32'h5a5a5a5a);
    rd_chk(REG_RESULT, last_r);
    // Fill the buffer with the drain stalled until requests are refused
    hold <= 1'b1;
    n0 = ntaken;
    repeat (FIFO_DEPTH) drv(4'(rnd()), 2'(rnd() % 3), rnd(), rnd());
    // One more request must wait until the drain restarts
    fork
      drv(4'(rnd()), 2'(rnd() % 3), rnd(), rnd());
      begin
        repeat (8) @(posedge i_clk);
        check(32'(ntaken - n0), 32'(FIFO_DEPTH));
        rd_chk(REG_STATUS, 32'h2004);
        slow <= 1'b1;
        hold <= 1'b0;
      end
    join
    idle(80);
    rd_chk(REG_STATUS, 32'h2);
    // Capture off must not change any product
    wr(REG_CTRL, 32'h0);
    cap = 1'b0;
    repeat (40) drv(4'(rnd()), 2'(rnd() % 3), rnd(), rnd());
    idle(8);
    rd_chk(REG_STATUS, 32'h2);
    wr(REG_CTRL, 32'h1);
    cap = 1'b1;
    print_verdict();
  end

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #500000;
    bad_count++;
    print_verdict();
  end

endmodule : bms_top_test
